// ### hw/serial_port.sv
// Serial port: low control register, pending flags, data register, frame engine
//
// Function
// RQ1: Low control register sits at F3h
// RQ2: Reset clears low control register
// RQ3: Bit 7 enables transmit parity generation
// RQ4: Bit 6 picks even or odd parity
// RQ5: Parity bits ignored while generation disabled
// RQ6: Bits 3:2 pick clock divide 8/4/2/1
// RQ7: Bit 1 enables transmit interrupt
// RQ8: Bit 0 transmit pending, write zero clears
// RQ9: Shift mode: receive pending after bit eight
// RQ10: Eight-bit mode: receive pending mid stop
// RQ11: Nine-bit modes: receive pending mid ninth
// RQ12: Software clears receive pending flag
// RQ13: Shift mode: transmit pending after bit eight
// RQ14: Async modes: transmit pending at stop start
// RQ15: Software clears transmit pending flag
// RQ16: Data register at F4h, reset zero
// RQ17: Write starts transmit, read returns receive buffer
// RQ18: High bits 7:6 select frame mode
// RQ19: High bit 0 receive pending, zero clears
// RQ20: Bit 5 receive parity, bit 4 error
// RQ21: Transmit interrupt is enable and pending
`timescale 1ns/1ns
module serial_port (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Serial pins: receive data is two-way in shift mode
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd,
  // Interrupt requests
  output logic tx_irq,
  output logic rx_irq
);
  // ==========================================================
  // Prescaler and input synchroniser
  logic ptick;
  logic [2:0] rx_sync_r;
  logic [2:0] rx_sync_nxt;
  logic rx_lvl_r;
  logic rx_lvl_nxt;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;

  // RQ6 clock divide select
  clk_prescaler u_pre (
    .clock(clock),
    .rstn(rstn),
    .sel(ctl_r[serial_pkg::clk_sel_hi:serial_pkg::clk_sel_lo]),
    .tick(ptick)
  );

  always_comb begin
    rx_sync_nxt = {rx_sync_r[1:0], rxd_in};
    rx_lvl_nxt = (rx_sync_r[1] == rx_sync_r[2]) ? rx_sync_r[2] : rx_lvl_r;
  end

  // ==========================================================
  // Registers and frame state
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_start = 2'b01,
    st_bits = 2'b10,
    st_stop = 2'b11
  } fsm_t;

  logic [7:0] cth_r, cth_nxt, txbuf_r, txbuf_nxt, rxbuf_r, rxbuf_nxt, baud_r, baud_nxt;
  fsm_t tst_r, tst_nxt, rst_r, rst_nxt;
  logic [8:0] tsh_r, tsh_nxt, rsh_r, rsh_nxt;
  logic [3:0] tbit_r, tbit_nxt, rbit_r, rbit_nxt;
  logic [3:0] tph_r, tph_nxt, rph_r, rph_nxt;
  logic [7:0] tdiv_r, tdiv_nxt, rdiv_r, rdiv_nxt;
  logic txd_r, txd_nxt, sclk_r, sclk_nxt;

  serial_pkg::mode_t mode;
  logic nine;
  logic wr_ctl, wr_cth, wr_dat, wr_baud, rd_dat;
  logic ttick, rtick, tx_done, rx_done, par_gen, par_bit;

  function automatic logic odd_of(input logic [7:0] d);
    odd_of = ^d;
  endfunction

  // Baud tick: fixed divide in mode 2, divisor otherwise, each tick one sixteenth bit
  function automatic logic bt(input logic [7:0] div, input serial_pkg::mode_t m);
    bt = (m == serial_pkg::mode_async9_fixed) ? 1'b1 : (div == 8'h00);
  endfunction

  always_comb begin
    mode = serial_pkg::mode_t'(cth_r[serial_pkg::mode_hi:serial_pkg::mode_lo]);
    nine = cth_r[serial_pkg::mode_hi];
    // RQ1 register decode
    wr_ctl = reg_wr && (reg_addr == serial_pkg::ctrl_low_addr);
    wr_cth = reg_wr && (reg_addr == serial_pkg::ctrl_high_addr);
    wr_dat = reg_wr && (reg_addr == serial_pkg::data_addr);
    wr_baud = reg_wr && (reg_addr == serial_pkg::baud_addr);
    rd_dat = reg_rd && (reg_addr == serial_pkg::data_addr);
    ttick = ptick && bt(tdiv_r, mode);
    rtick = ptick && bt(rdiv_r, mode);
    // RQ3 RQ4 parity generation
    par_gen = nine && ctl_r[serial_pkg::par_en_bit];
    par_bit = odd_of(txbuf_r) ^ ctl_r[serial_pkg::tx_par_odd_bit];
  end

  // ==========================================================
  // Transmit engine
  always_comb begin
    tst_nxt = tst_r;
    tsh_nxt = tsh_r;
    tbit_nxt = tbit_r;
    tph_nxt = tph_r;
    tdiv_nxt = tdiv_r;
    txd_nxt = txd_r;
    sclk_nxt = sclk_r;
    tx_done = 1'b0;
    txbuf_nxt = txbuf_r;
    if (ptick) begin
      tdiv_nxt = (tdiv_r == 8'h00) ? baud_r : tdiv_r - 8'h01;
    end
    if (ttick) begin
      tph_nxt = tph_r + 4'h1;
    end
    unique case (tst_r)
      st_idle: begin
        txd_nxt = 1'b1;
        sclk_nxt = 1'b1;
        // RQ17 write starts transmission
        if (wr_dat) begin
          txbuf_nxt = reg_wdata;
          tsh_nxt = {1'b1, reg_wdata};
          tst_nxt = st_start;
          tbit_nxt = 4'h0;
          tph_nxt = 4'h0;
        end
      end
      st_start: begin
        if (mode == serial_pkg::mode_shift) begin
          tst_nxt = st_bits;
        end else begin
          txd_nxt = 1'b0;
          if (par_gen) begin
            tsh_nxt[8] = par_bit;
          end else begin
            tsh_nxt[8] = cth_r[serial_pkg::ninth_tx_bit];
          end
          if (ttick && tph_r == 4'hf) begin
            tst_nxt = st_bits;
          end
        end
      end
      st_bits: begin
        txd_nxt = tsh_r[0];
        if (mode == serial_pkg::mode_shift) begin
          sclk_nxt = (tph_r < 4'h8) ? 1'b0 : 1'b1;
        end
        if (ttick && tph_r == 4'hf) begin
          tsh_nxt = {1'b1, tsh_r[8:1]};
          tbit_nxt = tbit_r + 4'h1;
          if (tbit_r == (nine ? 4'h8 : 4'h7)) begin
            tst_nxt = (mode == serial_pkg::mode_shift) ? st_idle : st_stop;
            // RQ13 RQ14 pending at eighth shift or stop start
            tx_done = 1'b1;
          end
        end
      end
      st_stop: begin
        txd_nxt = 1'b1;
        if (ttick && tph_r == 4'hf) begin
          tst_nxt = st_idle;
        end
      end
    endcase
  end

  // ==========================================================
  // Receive engine (mid-bit sampling)
  logic mid;
  logic perr;
  always_comb begin
    rst_nxt = rst_r;
    rsh_nxt = rsh_r;
    rbit_nxt = rbit_r;
    rph_nxt = rph_r;
    rdiv_nxt = rdiv_r;
    rxbuf_nxt = rxbuf_r;
    rx_done = 1'b0;
    perr = 1'b0;
    mid = rtick && (rph_r == 4'h7);
    if (ptick) begin
      rdiv_nxt = (rdiv_r == 8'h00) ? baud_r : rdiv_r - 8'h01;
    end
    if (rtick) begin
      rph_nxt = rph_r + 4'h1;
    end
    unique case (rst_r)
      st_idle: begin
        rph_nxt = 4'h0;
        rbit_nxt = 4'h0;
        if (cth_r[serial_pkg::rx_en_bit]) begin
          if (mode == serial_pkg::mode_shift) begin
            if (!cth_r[serial_pkg::rx_pend_bit]) begin
              rst_nxt = st_bits;
            end
          end else if (!rx_lvl_r) begin
            rst_nxt = st_start;
          end
        end
      end
      st_start: begin
        if (mid) begin
          rst_nxt = rx_lvl_r ? st_idle : st_bits;
          rph_nxt = 4'h8;
        end
      end
      st_bits: begin
        if (mid) begin
          rsh_nxt = {rx_lvl_r, rsh_r[8:1]};
          rbit_nxt = rbit_r + 4'h1;
          if (mode == serial_pkg::mode_shift && rbit_r == 4'h7) begin
            // RQ9 pending after eighth bit
            rxbuf_nxt = {rx_lvl_r, rsh_r[8:2]};
            rx_done = 1'b1;
            rst_nxt = st_idle;
          end else if (nine && rbit_r == 4'h8) begin
            // RQ11 pending mid ninth bit
            rxbuf_nxt = rsh_r[8:1];
            rx_done = !cth_r[serial_pkg::mce_bit] || rx_lvl_r;
            // RQ20 RQ5 parity check only when enabled
            perr = ctl_r[serial_pkg::par_en_bit]
              && ((odd_of(rsh_r[8:1]) ^ ctl_r[serial_pkg::rx_par_odd_bit]) != rx_lvl_r);
            rst_nxt = st_stop;
          end else if (!nine && mode != serial_pkg::mode_shift && rbit_r == 4'h7) begin
            rxbuf_nxt = {rx_lvl_r, rsh_r[8:2]};
            rst_nxt = st_stop;
          end
        end
      end
      st_stop: begin
        if (mid) begin
          // RQ10 pending mid stop bit
          if (!nine) begin
            rx_done = !cth_r[serial_pkg::mce_bit] || rx_lvl_r;
          end
          rst_nxt = st_idle;
        end
      end
    endcase
  end

  // ==========================================================
  // Control registers
  always_comb begin
    ctl_nxt = ctl_r;
    cth_nxt = cth_r;
    baud_nxt = baud_r;
    if (wr_ctl) begin
      ctl_nxt = reg_wdata;
    end
    if (wr_cth) begin
      cth_nxt = reg_wdata;
    end
    if (wr_baud) begin
      baud_nxt = reg_wdata;
    end
    // RQ8 RQ15 set wins over software clear
    if (tx_done) begin
      ctl_nxt[serial_pkg::tx_pend_bit] = 1'b1;
    end
    // RQ19 RQ12 receive pending, set wins
    if (rx_done) begin
      cth_nxt[serial_pkg::rx_pend_bit] = 1'b1;
    end
    if (perr) begin
      ctl_nxt[serial_pkg::par_err_bit] = 1'b1;
    end
    if (rst_r == st_bits && nine && mid && rbit_r == 4'h8
        && !ctl_r[serial_pkg::par_en_bit]) begin
      cth_nxt[serial_pkg::ninth_rx_bit] = rx_lvl_r;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      // RQ2 RQ16 reset values
      ctl_r <= serial_pkg::ctrl_low_reset;
      cth_r <= serial_pkg::ctrl_high_reset;
      baud_r <= serial_pkg::baud_reset;
      txbuf_r <= serial_pkg::data_reset;
      rxbuf_r <= serial_pkg::data_reset;
      rx_sync_r <= 3'h7;
      rx_lvl_r <= 1'b1;
      tst_r <= st_idle;
      rst_r <= st_idle;
      tsh_r <= 9'h1ff;
      rsh_r <= 9'h000;
      tbit_r <= 4'h0;
      rbit_r <= 4'h0;
      tph_r <= 4'h0;
      rph_r <= 4'h0;
      tdiv_r <= 8'h00;
      rdiv_r <= 8'h00;
      txd_r <= 1'b1;
      sclk_r <= 1'b1;
    end else begin
      ctl_r <= ctl_nxt;
      cth_r <= cth_nxt;
      baud_r <= baud_nxt;
      txbuf_r <= txbuf_nxt;
      rxbuf_r <= rxbuf_nxt;
      rx_sync_r <= rx_sync_nxt;
      rx_lvl_r <= rx_lvl_nxt;
      tst_r <= tst_nxt;
      rst_r <= rst_nxt;
      tsh_r <= tsh_nxt;
      rsh_r <= rsh_nxt;
      tbit_r <= tbit_nxt;
      rbit_r <= rbit_nxt;
      tph_r <= tph_nxt;
      rph_r <= rph_nxt;
      tdiv_r <= tdiv_nxt;
      rdiv_r <= rdiv_nxt;
      txd_r <= txd_nxt;
      sclk_r <= sclk_nxt;
    end
  end

  // ==========================================================
  // Outputs
  always_comb begin
    unique case (reg_addr)
      serial_pkg::ctrl_low_addr: reg_rdata = ctl_r;
      serial_pkg::ctrl_high_addr: reg_rdata = cth_r;
      // RQ17 read returns receive buffer
      serial_pkg::data_addr: reg_rdata = rxbuf_r;
      serial_pkg::baud_addr: reg_rdata = baud_r;
      default: reg_rdata = 8'h00;
    endcase
    // RQ18 shift mode drives data out on receive pin, clock on transmit pin
    rxd_oe = (mode == serial_pkg::mode_shift) && (tst_r != st_idle);
    rxd_out = txd_r;
    txd = (mode == serial_pkg::mode_shift) ? sclk_r : txd_r;
    // RQ7 RQ21 transmit request gated by enable
    tx_irq = ctl_r[serial_pkg::tx_ie_bit] && ctl_r[serial_pkg::tx_pend_bit];
    rx_irq = cth_r[serial_pkg::rx_ie_bit] && cth_r[serial_pkg::rx_pend_bit];
  end

  logic unused_rd;
  assign unused_rd = rd_dat;
endmodule // serial_port

// ### inc/serial_pkg.sv
// Shared register map, field positions and mode codes for the serial port block
package serial_pkg;
  // Register addresses (first register set, bank zero)
  localparam logic [7:0] ctrl_high_addr = 8'hf2;
  localparam logic [7:0] ctrl_low_addr = 8'hf3;
  localparam logic [7:0] data_addr = 8'hf4;
  localparam logic [7:0] baud_addr = 8'hf5;
  // Reset values
  localparam logic [7:0] ctrl_low_reset = 8'h00;
  localparam logic [7:0] ctrl_high_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;
  localparam logic [7:0] baud_reset = 8'h00;
  // Low control fields
  localparam int par_en_bit = 7;
  localparam int tx_par_odd_bit = 6;
  localparam int rx_par_odd_bit = 5;
  localparam int par_err_bit = 4;
  localparam int clk_sel_hi = 3;
  localparam int clk_sel_lo = 2;
  localparam int tx_ie_bit = 1;
  localparam int tx_pend_bit = 0;
  // High control fields
  localparam int mode_hi = 7;
  localparam int mode_lo = 6;
  localparam int mce_bit = 5;
  localparam int rx_en_bit = 4;
  localparam int ninth_tx_bit = 3;
  localparam int ninth_rx_bit = 2;
  localparam int rx_ie_bit = 1;
  localparam int rx_pend_bit = 0;
  // Mode codes
  typedef enum logic [1:0] {
    mode_shift = 2'b00,
    mode_async8 = 2'b01,
    mode_async9_fixed = 2'b10,
    mode_async9_var = 2'b11
  } mode_t;
  // Oversampling factor of the asynchronous modes
  localparam int oversample = 16;
endpackage

// ### hw/clk_prescaler.sv
// Serial clock prescaler: divides the system clock by 8, 4, 2 or 1
`timescale 1ns/1ns
module clk_prescaler (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Selection and output tick
  input wire logic [1:0] sel,
  output logic tick
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  always_comb begin
    cnt_nxt = cnt_r + 3'h1;
    unique case (sel)
      2'b00: tick = (cnt_r == 3'h7);
      2'b01: tick = (cnt_r[1:0] == 2'h3);
      2'b10: tick = cnt_r[0];
      2'b11: tick = 1'b1;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      cnt_r <= 3'h0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule // clk_prescaler

// ### tb/serial_port_chk.sv
// Port checker for the serial port block
`timescale 1ns/1ns
module serial_port_chk (
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Pins and requests
  input wire logic rxd_in,
  input wire logic rxd_oe,
  input wire logic txd,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================
  // Mode copy, so frame checks know the framing
  always_comb begin
    mode_nxt = mode_r;
    if (reg_wr && reg_addr == serial_pkg::ctrl_high_addr) begin
      mode_nxt = reg_wdata[7:6];
    end
  end
  always_ff @(posedge clock) begin
    mode_r <= rstn ? mode_nxt : 2'h0;
  end
  sequence s_stop_hold;
    txd [*8];
  endsequence
  // ==========================================
  // Properties
  a_tx_irq_and: assert property (
    reg_addr == serial_pkg::ctrl_low_addr |-> tx_irq == (reg_rdata[1] & reg_rdata[0]))
    else $error("tx request not enable and pending");
  a_rx_irq_and: assert property (
    reg_addr == serial_pkg::ctrl_high_addr |-> rx_irq == (reg_rdata[1] & reg_rdata[0]))
    else $error("rx request not enable and pending");
  a_rst_idle: assert property (
    $rose(rstn) |-> txd && !tx_irq && !rx_irq && !rxd_oe)
    else $error("outputs not idle after reset");
  a_ctrl_write: assert property (
    reg_wr && reg_addr == serial_pkg::ctrl_low_addr |=> reg_addr != serial_pkg::ctrl_low_addr
    || (reg_rdata[7:5] == $past(reg_wdata[7:5]) && reg_rdata[3:1] == $past(reg_wdata[3:1])))
    else $error("control write not kept");
  a_unmapped_zero: assert property (
    reg_addr < serial_pkg::ctrl_high_addr || reg_addr > serial_pkg::baud_addr
    |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_start_len: assert property (
    mode_r != serial_pkg::mode_shift && $fell(txd) |-> !txd [*8])
    else $error("start bit too short");
  a_stop_pend: assert property (
    mode_r != serial_pkg::mode_shift && $rose(tx_irq) |-> ##[0:1] s_stop_hold)
    else $error("tx pending not at stop bit");
  a_rx_stop: assert property (
    mode_r == serial_pkg::mode_async8 && $rose(rx_irq) |-> rxd_in)
    else $error("rx pending outside stop bit");
endmodule // serial_port_chk

// ### tb/remote_serial.sv
// Far-end serial device model
`timescale 1ns/1ns
module remote_serial (
  // Clock
  input wire logic clock,
  // Serial lines
  input wire logic txd,
  output logic rxd
);
  // Line rests at mark level between frames
  initial rxd = 1'b1;
  // Start, n bits LSB first, stop; bl cycles a bit
  task automatic send(input int bl, input int n, input logic [8:0] w);
    @(negedge clock);
    rxd = 1'b0;
    for (int i = 0; i <= n; i++) begin
      repeat (bl) @(negedge clock);
      rxd = (i == n) ? 1'b1 : w[i];
    end
    repeat (bl) @(negedge clock);
  endtask
  // Mid-bit samples of n bits and the stop bit
  task automatic get(input int bl, input int n, output logic [9:0] r);
    r = '1;
    @(negedge txd);
    repeat (bl / 2) @(negedge clock);
    for (int i = 0; i <= n; i++) begin
      repeat (bl) @(negedge clock);
      r[i] = txd;
    end
    repeat (bl / 2 + 1) @(negedge clock);
  endtask
endmodule // remote_serial

// ### tb/testbench.sv
// Self-checking bench for the serial port block
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin miscompares++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module testbench;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic rxd_out, rxd_oe, txd, tx_irq, rx_irq, far_rxd, rxd_in;
  int miscompares = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] v;
  logic [9:0] d;
  // Receive pin is shared with the shift-mode drive
  assign rxd_in = rxd_oe ? rxd_out : far_rxd;
  always #2 clock = ~clock;
  serial_port i_dut (.clock, .rstn, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .rxd_in, .rxd_out, .rxd_oe, .txd, .tx_irq, .rx_irq);
  remote_serial i_far (.clock, .txd, .rxd(far_rxd));
  // ==========================================
  // Register access
  task automatic wr(input logic [7:0] a, input logic [7:0] w);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = w;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clock);
    v = reg_rdata;
    @(negedge clock);
    reg_rd = 1'b0;
  endtask
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset();
    rd(serial_pkg::ctrl_low_addr);
    `CHK(v, serial_pkg::ctrl_low_reset)
    rd(serial_pkg::data_addr);
    `CHK(v, 8'h00)
    rd(8'hf0);
    `CHK(v, 8'h00)
    wr(serial_pkg::ctrl_low_addr, 8'hee);
    rd(serial_pkg::ctrl_low_addr);
    `CHK(v, 8'hee)
    $display("t_reset done");
  endtask
  task automatic t_clk();
    int n;
    wr(serial_pkg::ctrl_high_addr, 8'h40);
    for (int s = 0; s < 4; s++) begin
      wr(serial_pkg::ctrl_low_addr, {4'h0, s[1:0], 2'b00});
      wr(serial_pkg::data_addr, 8'h01);
      // Time the high bit 0: the start bit is cut short by the free-running prescaler phase
      @(posedge txd);
      @(negedge clock);
      n = 0;
      while (txd === 1'b1 && n < 300) begin
        n++;
        @(negedge clock);
      end
      `CHK(n, 16 << (3 - s))
      repeat (160 << (3 - s)) @(negedge clock);
    end
    $display("t_clk done");
  endtask
  task automatic t_tx();
    wr(serial_pkg::ctrl_low_addr, 8'h0e);
    wr(serial_pkg::data_addr, 8'ha5);
    i_far.get(16, 8, d);
    `CHK(d[8:0], 9'h1a5)
    `CHK(tx_irq, 1'b1)
    wr(serial_pkg::ctrl_low_addr, 8'h0d);
    `CHK(tx_irq, 1'b0)
    rd(serial_pkg::ctrl_low_addr);
    `CHK(v, 8'h0d)
    wr(serial_pkg::ctrl_low_addr, 8'h0c);
    rd(serial_pkg::ctrl_low_addr);
    `CHK(v, 8'h0c)
    wr(serial_pkg::data_addr, 8'h5a);
    i_far.get(16, 8, d);
    `CHK(d[8:0], 9'h15a)
    rd(serial_pkg::ctrl_low_addr);
    `CHK(v, 8'h0d)
    `CHK(tx_irq, 1'b0)
    wr(serial_pkg::ctrl_low_addr, 8'h0f);
    `CHK(tx_irq, 1'b1)
    wr(serial_pkg::ctrl_low_addr, 8'h0e);
    `CHK(tx_irq, 1'b0)
    $display("t_tx done");
  endtask
  task automatic t_par();
    logic [7:0] cfg [3] = '{8'h8c, 8'hcc, 8'h4c};
    logic [2:0] exp = 3'b101;
    wr(serial_pkg::ctrl_high_addr, 8'h88);
    for (int i = 0; i < 3; i++) begin
      wr(serial_pkg::ctrl_low_addr, cfg[i]);
      wr(serial_pkg::data_addr, 8'h07);
      i_far.get(16, 9, d);
      `CHK(d[9:8], {1'b1, exp[i]})
    end
    $display("t_par done");
  endtask
  task automatic t_rx();
    wr(serial_pkg::ctrl_low_addr, 8'h0c);
    wr(serial_pkg::ctrl_high_addr, 8'h52);
    i_far.send(16, 8, 9'h03c);
    `CHK(rx_irq, 1'b1)
    rd(serial_pkg::data_addr);
    `CHK(v, 8'h3c)
    wr(serial_pkg::ctrl_high_addr, 8'h52);
    `CHK(rx_irq, 1'b0)
    wr(serial_pkg::ctrl_low_addr, 8'hac);
    wr(serial_pkg::ctrl_high_addr, 8'hd2);
    i_far.send(16, 9, 9'h101);
    `CHK(rx_irq, 1'b1)
    rd(serial_pkg::ctrl_low_addr);
    `CHK(v[4], 1'b1)
    wr(serial_pkg::ctrl_high_addr, 8'hd2);
    wr(serial_pkg::ctrl_low_addr, 8'hac);
    i_far.send(16, 9, 9'h001);
    rd(serial_pkg::ctrl_low_addr);
    `CHK(v[4], 1'b0)
    $display("t_rx done");
  endtask
  task automatic t_shift();
    logic [7:0] w = 8'h96;
    wr(serial_pkg::ctrl_high_addr, 8'h00);
    wr(serial_pkg::ctrl_low_addr, 8'h0e);
    wr(serial_pkg::data_addr, w);
    // Data must stand on the receive pin at each rising shift clock
    for (int i = 0; i < 8; i++) begin
      @(posedge txd);
      @(negedge clock);
      `CHK({rxd_oe, rxd_out, tx_irq}, {1'b1, w[i], 1'b0})
    end
    repeat (8) @(negedge clock);
    `CHK({rxd_oe, tx_irq}, 2'b01)
    // Idle far line shifts in all ones
    wr(serial_pkg::ctrl_high_addr, 8'h12);
    repeat (116) @(negedge clock);
    `CHK(rx_irq, 1'b0)
    repeat (8) @(negedge clock);
    `CHK(rx_irq, 1'b1)
    rd(serial_pkg::data_addr);
    `CHK(v, 8'hff)
    wr(serial_pkg::ctrl_high_addr, 8'h00);
    $display("t_shift done");
  endtask
  task automatic t_rerst();
    wr(serial_pkg::ctrl_low_addr, 8'h5c);
    @(negedge clock);
    rstn = 1'b0;
    repeat (2) @(negedge clock);
    rstn = 1'b1;
    rd(serial_pkg::ctrl_low_addr);
    `CHK(v, serial_pkg::ctrl_low_reset)
    rd(serial_pkg::data_addr);
    `CHK(v, serial_pkg::data_reset)
    $display("t_rerst done");
  endtask
  // Ceiling well above the few thousand cycles the scenarios need
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge clock);
    @(negedge clock);
    rstn = 1'b1;
    t_reset();
    t_clk();
    t_tx();
    t_par();
    t_rx();
    t_shift();
    t_rerst();
    results();
  end
endmodule // testbench
bind serial_port serial_port_chk i_chk (.clock, .rstn, .reg_addr, .reg_wr, .reg_wdata,
  .reg_rdata, .rxd_in, .rxd_oe, .txd, .tx_irq, .rx_irq);
